// [design/ism_top.sv]
// Local design decisions: the register offsets and the APB slave port.
`default_nettype none
// Functional notes
// - flag and enable bit of irq n live in bank n/32, bit n%32.
// - core timer is irq 0, vector 0, slot 0 of priority reg 0, non-persistent.
// - core soft sources irq 1,2 use vectors 1,2, slots 1,2, non-persistent.
// - four slots per priority reg: prio 4:2/12:10/20:18/28:26, sub below.
// - external requests 1-4 are irqs 8,13,18,23, vectors 7,11,15,19, top slot.
// - capture error and capture share one vector and field pair; persistent.
// - compare outputs 1-5 irqs 7,12,17,22,27, vectors 6,10,14,18,22, slot 2.
// - conversion done is irq 28, vector 23, reg 5 top slot, persistent.
// - clock fail is irq 29, vector 24, reg 6 slot 0, non-persistent.
// - calendar is irq 30, vector 25, reg 6 slot 1, non-persistent.
// - flash event is irq 31, vector 26, bank 0 bit 31, non-persistent.
// - comparators irqs 32-34, vectors 27-29, bank 1 bits 0-2.
// - usb is irq 35, vector 30, reg 7 slot 2, persistent.
// - serial fault, receive, transmit irqs 36-38 share vector 31; persistent.
// - priority zero disables a source; 7 is highest.
// - subpriority 0-3 orders sources of equal priority.
module ism_top #(
  parameter int NUM_SRC = ism_pkg::NUM_SRC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_SRC-1:0] src_req,
  output logic core_req,
  output logic [4:0] core_vector,
  output logic [2:0] core_priority,
  output logic [1:0] core_subpriority,
  output logic irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [31:0] flag_bank_0;
  logic [ism_pkg::FLAG1_BITS-1:0] flag_bank_1;
  logic [31:0] enable_bank_0;
  logic [ism_pkg::FLAG1_BITS-1:0] enable_bank_1;
  logic [31:0] priority_reg_n [0:ism_pkg::NUM_PRIO_REG-1];
  logic [NUM_SRC-1:0] req_d;
  logic [ism_pkg::EVT_BITS-1:0] irq_status;
  logic [ism_pkg::EVT_BITS-1:0] irq_enable;
  logic [NUM_SRC-1:0] set_ev;
  logic [NUM_SRC-1:0] flags;
  logic [NUM_SRC-1:0] enables;
  logic [ism_pkg::NUM_VEC-1:0] vec_pend;
  logic [2:0] slot_prio [0:ism_pkg::NUM_VEC-1];
  logic [1:0] slot_sub [0:ism_pkg::NUM_VEC-1];
  logic ch_valid [0:ism_pkg::NUM_VEC];
  logic [2:0] ch_prio [0:ism_pkg::NUM_VEC];
  logic [1:0] ch_sub [0:ism_pkg::NUM_VEC];
  logic [4:0] ch_vec [0:ism_pkg::NUM_VEC];
  logic setup;
  logic wr_acc;
  logic [31:0] next_rdata;
  logic next_err;
  logic [ism_pkg::EVT_BITS-1:0] evt;
  logic [ism_pkg::EVT_BITS-1:0] clr_mask;

  // ---------------------------------------------------------------
  // apb handshake
  // ---------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // ---------------------------------------------------------------
  // request edge tracking
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_d <= '0;
    end else begin
      req_d <= src_req;
    end
  end

  // persistent sources re-set while asserted, others on the rising edge
  assign set_ev = (src_req & ism_pkg::PERSIST_MASK[NUM_SRC-1:0]) |
                  (src_req & ~req_d & ~ism_pkg::PERSIST_MASK[NUM_SRC-1:0]);

  // ---------------------------------------------------------------
  // flag banks, set wins over software write
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_bank_0 <= ism_pkg::RESET_WORD;
    end else if (wr_acc && paddr == ism_pkg::ADDR_FLAG0) begin
      flag_bank_0 <= pwdata | set_ev[31:0];
    end else begin
      flag_bank_0 <= flag_bank_0 | set_ev[31:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_bank_1 <= '0;
    end else if (wr_acc && paddr == ism_pkg::ADDR_FLAG1) begin
      flag_bank_1 <= pwdata[ism_pkg::FLAG1_BITS-1:0] | set_ev[NUM_SRC-1:32];
    end else begin
      flag_bank_1 <= flag_bank_1 | set_ev[NUM_SRC-1:32];
    end
  end

  // ---------------------------------------------------------------
  // enable banks
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_bank_0 <= ism_pkg::RESET_WORD;
      enable_bank_1 <= '0;
    end else if (wr_acc && paddr == ism_pkg::ADDR_EN0) begin
      enable_bank_0 <= pwdata;
    end else if (wr_acc && paddr == ism_pkg::ADDR_EN1) begin
      enable_bank_1 <= pwdata[ism_pkg::FLAG1_BITS-1:0];
    end
  end

  // ---------------------------------------------------------------
  // priority registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int r = 0; r < ism_pkg::NUM_PRIO_REG; r++) begin
        priority_reg_n[r] <= ism_pkg::RESET_WORD;
      end
    end else begin
      for (int r = 0; r < ism_pkg::NUM_PRIO_REG; r++) begin
        if (wr_acc && paddr == ism_pkg::ADDR_PRIO_BASE + 8'(4 * r)) begin
          priority_reg_n[r] <= pwdata & ism_pkg::PRIO_REG_MASK;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // per-vector pending and field extraction
  // ---------------------------------------------------------------
  assign flags = {flag_bank_1, flag_bank_0};
  assign enables = {enable_bank_1, enable_bank_0};

  always_comb begin
    vec_pend = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (flags[i] && enables[i]) begin
        vec_pend[ism_pkg::VEC_OF[i]] = 1'b1;
      end
    end
  end

  // vector v owns slot v%4 of priority register v/4
  always_comb begin
    for (int v = 0; v < ism_pkg::NUM_VEC; v++) begin
      slot_prio[v] = priority_reg_n[v / ism_pkg::SLOTS_PER_REG][
        (v % ism_pkg::SLOTS_PER_REG) * ism_pkg::SLOT_STRIDE + ism_pkg::PRIO_LSB +: 3];
      slot_sub[v] = priority_reg_n[v / ism_pkg::SLOTS_PER_REG][
        (v % ism_pkg::SLOTS_PER_REG) * ism_pkg::SLOT_STRIDE + ism_pkg::SUB_LSB +: 2];
    end
  end

  // ---------------------------------------------------------------
  // arbitration chain, lowest vector first
  // ---------------------------------------------------------------
  assign ch_valid[0] = 1'b0;
  assign ch_prio[0] = ism_pkg::PRIO_OFF;
  assign ch_sub[0] = 2'h0;
  assign ch_vec[0] = 5'h00;

  for (genvar g = 0; g < ism_pkg::NUM_VEC; g++) begin : g_pick
    ism_pick u_pick (
      .best_valid(ch_valid[g]),
      .best_prio(ch_prio[g]),
      .best_sub(ch_sub[g]),
      .best_vec(ch_vec[g]),
      .cand_valid(vec_pend[g] && slot_prio[g] != ism_pkg::PRIO_OFF),
      .cand_prio(slot_prio[g]),
      .cand_sub(slot_sub[g]),
      .cand_vec(5'(g)),
      .out_valid(ch_valid[g+1]),
      .out_prio(ch_prio[g+1]),
      .out_sub(ch_sub[g+1]),
      .out_vec(ch_vec[g+1])
    );
  end

  // ---------------------------------------------------------------
  // core request outputs
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_req <= 1'b0;
      core_vector <= 5'h00;
      core_priority <= 3'h0;
      core_subpriority <= 2'h0;
    end else begin
      core_req <= ch_valid[ism_pkg::NUM_VEC];
      core_vector <= ch_valid[ism_pkg::NUM_VEC] ? ch_vec[ism_pkg::NUM_VEC] : 5'h00;
      core_priority <= ch_valid[ism_pkg::NUM_VEC] ? ch_prio[ism_pkg::NUM_VEC] : 3'h0;
      core_subpriority <= ch_valid[ism_pkg::NUM_VEC] ? ch_sub[ism_pkg::NUM_VEC] : 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // block interrupt: request rise and winner change
  // ---------------------------------------------------------------
  always_comb begin
    evt = '0;
    evt[ism_pkg::EVT_RISE] = ch_valid[ism_pkg::NUM_VEC] && !core_req;
    evt[ism_pkg::EVT_CHANGE] = ch_valid[ism_pkg::NUM_VEC] && core_req &&
                               (ch_vec[ism_pkg::NUM_VEC] != core_vector);
    clr_mask = '0;
    if (wr_acc && paddr == ism_pkg::ADDR_IRQ_CLR) begin
      clr_mask = pwdata[ism_pkg::EVT_BITS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~clr_mask) | evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= '0;
    end else if (wr_acc && paddr == ism_pkg::ADDR_IRQ_EN) begin
      irq_enable <= pwdata[ism_pkg::EVT_BITS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status & ~clr_mask) | evt) & irq_enable);
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = ism_pkg::RESET_WORD;
    next_err = 1'b0;
    case (paddr)
      ism_pkg::ADDR_FLAG0: next_rdata = flag_bank_0;
      ism_pkg::ADDR_FLAG1: next_rdata[ism_pkg::FLAG1_BITS-1:0] = flag_bank_1;
      ism_pkg::ADDR_EN0: next_rdata = enable_bank_0;
      ism_pkg::ADDR_EN1: next_rdata[ism_pkg::FLAG1_BITS-1:0] = enable_bank_1;
      ism_pkg::ADDR_WIN: begin
        next_rdata[ism_pkg::WIN_VALID] = core_req;
        next_rdata[9:0] = {core_subpriority, core_priority, core_vector};
      end
      ism_pkg::ADDR_IRQ_STAT: next_rdata[ism_pkg::EVT_BITS-1:0] = irq_status;
      ism_pkg::ADDR_IRQ_CLR: next_rdata = ism_pkg::RESET_WORD;
      ism_pkg::ADDR_IRQ_EN: next_rdata[ism_pkg::EVT_BITS-1:0] = irq_enable;
      default: begin
        if (paddr >= ism_pkg::ADDR_PRIO_BASE && paddr < ism_pkg::ADDR_WIN &&
            paddr[1:0] == 2'h0) begin
          next_rdata = priority_reg_n[3'(paddr[4:2])];
        end else begin
          next_err = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= ism_pkg::RESET_WORD;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? ism_pkg::RESET_WORD : next_rdata;
      pslverr <= next_err;
    end else begin
      pslverr <= 1'b0;
    end
  end
endmodule : ism_top
`default_nettype wire

// [design/ism_pkg.sv]
`default_nettype none
package ism_pkg;
  // ---------------------------------------------------------------
  // source map
  // ---------------------------------------------------------------
  localparam int NUM_SRC = 39;
  localparam int NUM_VEC = 32;
  localparam int NUM_PRIO_REG = 8;
  localparam int BANK_BITS = 32;
  localparam int FLAG1_BITS = 7;
  localparam logic [4:0] VEC_OF [0:NUM_SRC-1] = '{
    5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h05, 5'h06,
    5'h07, 5'h08, 5'h09, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
    5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h11, 5'h12, 5'h13,
    5'h14, 5'h15, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A,
    5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h1F, 5'h1F, 5'h1F};
  localparam logic [38:0] PERSIST_MASK = 39'h78_1631_8C60;
  // ---------------------------------------------------------------
  // priority field layout
  // ---------------------------------------------------------------
  localparam int SLOTS_PER_REG = 4;
  localparam int SLOT_STRIDE = 8;
  localparam int PRIO_LSB = 2;
  localparam int SUB_LSB = 0;
  localparam logic [31:0] PRIO_REG_MASK = 32'h1F1F_1F1F;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_FLAG0 = 8'h00;
  localparam logic [7:0] ADDR_FLAG1 = 8'h04;
  localparam logic [7:0] ADDR_EN0 = 8'h10;
  localparam logic [7:0] ADDR_EN1 = 8'h14;
  localparam logic [7:0] ADDR_PRIO_BASE = 8'h20;
  localparam logic [7:0] ADDR_WIN = 8'h40;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h50;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h54;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h58;
  // event bits of the interrupt status register
  localparam int EVT_RISE = 0;
  localparam int EVT_CHANGE = 1;
  localparam int EVT_BITS = 2;
  // winner register layout: valid 31, sub 9:8, prio 7:5, vector 4:0
  localparam int WIN_VALID = 31;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage : ism_pkg
`default_nettype wire

// [design/ism_pick.sv]
`default_nettype none
module ism_pick (
  input wire logic best_valid,
  input wire logic [2:0] best_prio,
  input wire logic [1:0] best_sub,
  input wire logic [4:0] best_vec,
  input wire logic cand_valid,
  input wire logic [2:0] cand_prio,
  input wire logic [1:0] cand_sub,
  input wire logic [4:0] cand_vec,
  output logic out_valid,
  output logic [2:0] out_prio,
  output logic [1:0] out_sub,
  output logic [4:0] out_vec
);
  logic take;
  // ---------------------------------------------------------------
  // compare one candidate against the running best
  // ---------------------------------------------------------------
  always_comb begin
    take = cand_valid && (!best_valid || (cand_prio > best_prio) ||
           ((cand_prio == best_prio) && (cand_sub > best_sub)));
    // ties keep the earlier, lower vector
    out_valid = best_valid | take;
    out_prio = take ? cand_prio : best_prio;
    out_sub = take ? cand_sub : best_sub;
    out_vec = take ? cand_vec : best_vec;
  end
endmodule : ism_pick
`default_nettype wire

// [dv/ism_monitor.sv]
`default_nettype none
module ism_monitor #(
  parameter int NUM_SRC = 39
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_SRC-1:0] src_req,
  input wire logic core_req,
  input wire logic [4:0] core_vector,
  input wire logic [2:0] core_priority,
  input wire logic [1:0] core_subpriority,
  input wire logic irq
);
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  idle_zero_a: assert property (!core_req |->
    core_vector == 5'h00 && core_priority == 3'h0 && core_subpriority == 2'h0)
    else $error("winner fields not zero while idle");
  prio_live_a: assert property (core_req |-> core_priority != 3'h0)
    else $error("request with priority zero");
  win_hold_a: assert property ((!psel && $stable(src_req))[*3] |=>
    $stable(core_vector) && $stable(core_req))
    else $error("winner moved with quiet inputs");
  rdy_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  rdy_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  hole_err_a: assert property (psel && !penable && paddr > 8'h58 |=> pslverr)
    else $error("unmapped address accepted");
  err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("error read data not zero");
  cover property ($rose(core_req));
  cover property ($rose(irq));
  cover property (pslverr);
endmodule : ism_monitor
bind ism_top ism_monitor #(.NUM_SRC(NUM_SRC)) u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req),
  .core_req(core_req), .core_vector(core_vector), .core_priority(core_priority),
  .core_subpriority(core_subpriority), .irq(irq));
`default_nettype wire

// [dv/ism_core_model.sv]
`default_nettype none
module ism_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic core_req,
  input wire logic [4:0] core_vector,
  output logic [4:0] taken_vec
);
  // ---------------------------------------------------------------
  // core takes the presented vector while a request stands
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taken_vec <= 5'h1F;
    end else if (core_req) begin
      taken_vec <= core_vector;
    end
  end
endmodule : ism_core_model
`default_nettype wire

// [dv/testbench.sv]
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // harness
  // ---------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, core_req, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [38:0] src_req;
  logic [4:0] core_vector, taken_vec;
  logic [2:0] core_priority;
  logic [1:0] core_subpriority;
  int err_count = 0;
  int n_checks = 0;
  int irq_t [18] = '{0, 1, 2, 3, 5, 6, 7, 8, 13, 28, 29, 30, 31, 32, 34, 35, 36, 38};
  int vec_t [18] = '{0, 1, 2, 3, 5, 5, 6, 7, 11, 23, 24, 25, 26, 27, 29, 30, 31, 31};
  int per_t [18] = '{0, 0, 0, 0, 1, 1, 0, 0, 0, 1, 0, 0, 0, 0, 0, 1, 1, 1};
  ism_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_req(src_req), .core_req(core_req), .core_vector(core_vector),
    .core_priority(core_priority), .core_subpriority(core_subpriority), .irq(irq));
  ism_core_model core (.pclk(pclk), .presetn(presetn), .core_req(core_req),
    .core_vector(core_vector), .taken_vec(taken_vec));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    logic [7:0] al [5] = '{8'h00, 8'h14, 8'h3C, 8'h40, 8'h58};
    foreach (al[i]) begin
      apb(1'b0, al[i], 32'h0);
      chk(rd, 32'h0);
    end
    $display("reset test done");
  endtask : test_reset
  task automatic test_map();
    int q, v, s;
    logic [7:0] b, pa;
    logic [31:0] m;
    for (int i = 0; i < 18; i++) begin
      q = irq_t[i];
      v = vec_t[i];
      b = 8'((q / 32) * 4);
      pa = 8'h20 + 8'((v / 4) * 4);
      s = (v % 4) * 8;
      m = 32'h1 << (q % 32);
      apb(1'b1, 8'h10 + b, m);
      apb(1'b1, pa, 32'h0E << s);
      src_req[q] <= 1'b1;
      cyc(5);
      chk(32'(core_vector), 32'(v));
      chk(32'({core_priority, core_subpriority}), 32'h0E);
      chk(32'(taken_vec), 32'(v));
      apb(1'b0, b, 32'h0);
      chk(rd, m);
      apb(1'b1, b, 32'h0);
      cyc(2);
      apb(1'b0, b, 32'h0);
      chk(rd, per_t[i] ? m : 32'h0);
      src_req[q] <= 1'b0;
      apb(1'b1, b, 32'h0);
      apb(1'b1, 8'h10 + b, 32'h0);
      apb(1'b1, pa, 32'h0);
    end
    $display("map test done");
  endtask : test_map
  task automatic test_prio();
    apb(1'b1, 8'h10, 32'h0000_0181);
    apb(1'b1, 8'h20, 32'h0000_0008);
    apb(1'b1, 8'h24, 32'h0909_0000);
    src_req <= 39'h181;
    cyc(5);
    chk(32'(core_vector), 32'h06);
    apb(1'b1, 8'h20, 32'h0000_0017);
    apb(1'b1, 8'h24, 32'h1800_0000);
    cyc(3);
    chk(32'({core_vector, core_priority}), 32'h3E);
    apb(1'b1, 8'h24, 32'h0900_0000);
    cyc(3);
    chk(32'({core_vector, core_subpriority}), 32'h03);
    apb(1'b1, 8'h20, 32'h0);
    cyc(3);
    chk(32'(core_vector), 32'h07);
    apb(1'b1, 8'h10, 32'h0);
    cyc(3);
    chk(32'(core_req), 32'h0);
    src_req <= '0;
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h24, 32'h0);
    $display("priority test done");
  endtask : test_prio
  task automatic test_irq();
    apb(1'b1, 8'h54, 32'h3);
    apb(1'b1, 8'h58, 32'h1);
    apb(1'b1, 8'h10, 32'h3);
    apb(1'b1, 8'h20, 32'h0000_1404);
    src_req <= 39'h1;
    cyc(5);
    chk(32'(irq), 32'h1);
    apb(1'b0, 8'h50, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 8'h58, 32'h0);
    cyc(3);
    chk(32'(irq), 32'h0);
    apb(1'b1, 8'h54, 32'h1);
    apb(1'b1, 8'h58, 32'h1);
    cyc(3);
    apb(1'b0, 8'h50, 32'h0);
    chk(32'({rd[0], irq}), 32'h0);
    apb(1'b1, 8'h58, 32'h2);
    src_req <= 39'h3;
    cyc(5);
    apb(1'b0, 8'h50, 32'h0);
    chk(32'({rd[1:0], irq, core_vector}), 32'hA1);
    apb(1'b0, 8'h60, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    src_req <= '0;
    $display("interrupt test done");
  endtask : test_irq
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    {psel, penable, pwrite, presetn, paddr, pwdata, src_req} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_map();
    test_prio();
    test_irq();
    give_verdict();
  end
  initial begin
    #500000;
    err_count++;
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
